//--- design/trc_defs.vh
/*
  constants of the template ram and receive configuration bank:
  register offsets, field positions, reset values and decode codes.
  assumes it is included once per compile unit by its bare name.
*/
// Overview of operation
// RQ1 - writing go bit runs one template access
// RQ2 - direction zero writes, one reads template ram
// RQ3 - two bit unit interval index, four intervals
// RQ4 - four bit tap index, sixteen samples each
// RQ5 - indirect write stores seven bit amplitude value
// RQ6 - indirect read returns stored amplitude to data
// RQ7 - power down bit switches receiver off
// RQ8 - polarity bit makes data outputs active low
// RQ9 - edge bit picks output clock edge, not slicer
// RQ10 - code 00 substitution decode, single rail nrz
// RQ11 - code 01 ami decode, single rail nrz
// RQ12 - code 10 retimed dual rail nrz output
// RQ13 - code 11 raw slicer rz dual rail
// RQ14 - equalizer bit enables equalizer and threshold
// RQ15 - threshold code steps levels by 2 db
// RQ16 - six bit pulse gain, resets to 100001
// RQ17 - address from interval and tap, 64 entries
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH
// register offsets within one channel
`define TRC_OFF_GAIN     8'h06
`define TRC_OFF_ACC      8'h07
`define TRC_OFF_AMP      8'h08
`define TRC_OFF_RCFG0    8'h09
`define TRC_OFF_RCFG1    8'h0a
// access control fields
`define TRC_ACC_GO       7
`define TRC_ACC_DIR      6
`define TRC_ACC_UI_HI    5
`define TRC_ACC_UI_LO    4
`define TRC_ACC_TAP_HI   3
`define TRC_ACC_TAP_LO   0
// receive config zero fields
`define TRC_RC0_PDN      4
`define TRC_RC0_FLIP     3
`define TRC_RC0_EDGE     2
`define TRC_RC0_DEC_HI   1
`define TRC_RC0_DEC_LO   0
// receive config one fields
`define TRC_RC1_EQ       6
`define TRC_RC1_THR_HI   4
`define TRC_RC1_THR_LO   0
// reset values
`define TRC_RST_GAIN     6'h21
`define TRC_RST_THR      5'h15
`define TRC_RST_ZERO8    8'h00
// decode choices
`define TRC_DEC_SUBST    2'h0
`define TRC_DEC_AMI      2'h1
`define TRC_DEC_DUAL     2'h2
`define TRC_DEC_SLICE    2'h3
// threshold: highest legal code and declare offset in db
`define TRC_THR_MAX      5'h0a
`define TRC_DECL_OFS_DB  6'h04
`endif

//--- design/trc_bank.v
/*
  one channel of the template ram access and receive configuration
  bank: host register port, 64 x 7 pulse template ram, receive
  decode and output stage with a two entry buffer, signal loss
  detection with programmable thresholds.
  assumes a synchronous host port on ref_clk and line rails that
  arrive asynchronously from the slicer.
*/
`include "trc_defs.vh"

module trc_bank
#(
  parameter [7:0] CHAN_BASE = 8'h00, // channel register base
  parameter       HALF_DIV  = 5      // ref cycles per half bit
)
(
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire [7:0] host_addr,
  input  wire       host_wr,
  input  wire       host_rd,
  input  wire [7:0] host_wdata,
  output reg  [7:0] host_rdata,
  input  wire [5:0] tx_tpl_addr,
  output reg  [6:0] tx_tpl_sample,
  output reg  [5:0] pulse_gain_factor,
  input  wire       rx_pos_in,
  input  wire       rx_neg_in,
  input  wire [5:0] rx_atten_db,
  input  wire       rx_hold,
  output reg        rx_recovered_clock,
  output reg        rx_single_rail_out,
  output reg        rx_positive_rail_out,
  output reg        rx_negative_rail_out,
  output reg        rx_power_down,
  output reg        equalizer_engage,
  output reg  [4:0] no_signal_threshold,
  output reg        rx_signal_lost
);

  ////////////////////////////////////////////////////////////////////
  // register state
  reg  [7:0] acc_r;
  reg  [6:0] amplitude_value_r;
  reg  [4:0] rcfg0_r;
  reg        eq_r;
  reg  [4:0] thr_r;
  reg  [6:0] tpl_mem [0:63];
  wire [7:0] loc = host_addr - CHAN_BASE;
  wire [1:0] unit_interval_index = acc_r[`TRC_ACC_UI_HI:`TRC_ACC_UI_LO];
  wire [3:0] tap_index = acc_r[`TRC_ACC_TAP_HI:`TRC_ACC_TAP_LO];
  wire [5:0] tpl_idx = {unit_interval_index, tap_index}; // [RQ17] [RQ3] [RQ4]
  wire       flip = rcfg0_r[`TRC_RC0_FLIP];
  wire       pdn = rcfg0_r[`TRC_RC0_PDN];
  wire [1:0] rx_decode_choice = rcfg0_r[`TRC_RC0_DEC_HI:`TRC_RC0_DEC_LO];

  // host writes; the go bit self clears one cycle after it is set
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_r <= `TRC_RST_ZERO8;
      amplitude_value_r <= 7'h00;
      rcfg0_r <= 5'h00;
      eq_r <= 1'b0;
      thr_r <= `TRC_RST_THR;
      pulse_gain_factor <= `TRC_RST_GAIN; // [RQ16]
    end
    else
    begin
      if (acc_r[`TRC_ACC_GO])
      begin
        acc_r[`TRC_ACC_GO] <= 1'b0; // [RQ1]
        if (acc_r[`TRC_ACC_DIR])
          amplitude_value_r <= tpl_mem[tpl_idx]; // [RQ2] [RQ6]
      end
      if (host_wr)
      begin
        case (loc)
          `TRC_OFF_GAIN:  pulse_gain_factor <= host_wdata[5:0];
          `TRC_OFF_ACC:   acc_r <= host_wdata;
          `TRC_OFF_AMP:   amplitude_value_r <= host_wdata[6:0];
          `TRC_OFF_RCFG0: rcfg0_r <= host_wdata[4:0];
          `TRC_OFF_RCFG1:
          begin
            eq_r <= host_wdata[`TRC_RC1_EQ];
            thr_r <= host_wdata[`TRC_RC1_THR_HI:`TRC_RC1_THR_LO];
          end
          default: ;
        endcase
      end
    end
  end

  // template ram: written only by a go with direction zero
  integer k;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (k = 0; k < 64; k = k + 1)
        tpl_mem[k] <= 7'h00;
    end
    else if (acc_r[`TRC_ACC_GO] && !acc_r[`TRC_ACC_DIR])
      tpl_mem[tpl_idx] <= amplitude_value_r; // [RQ1] [RQ2] [RQ5]
  end

  // host read data and transmitter sample port, both registered
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_rdata <= `TRC_RST_ZERO8;
      tx_tpl_sample <= 7'h00;
    end
    else
    begin
      tx_tpl_sample <= tpl_mem[tx_tpl_addr];
      if (host_rd)
      begin
        case (loc)
          `TRC_OFF_GAIN:  host_rdata <= {2'b00, pulse_gain_factor};
          `TRC_OFF_ACC:   host_rdata <= acc_r;
          `TRC_OFF_AMP:   host_rdata <= {1'b0, amplitude_value_r};
          `TRC_OFF_RCFG0: host_rdata <= {3'b000, rcfg0_r};
          `TRC_OFF_RCFG1: host_rdata <= {1'b0, eq_r, 1'b0, thr_r};
          default:        host_rdata <= `TRC_RST_ZERO8;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // rail synchronisers: three stages, change taken when last two agree
  reg [2:0] pos_s;
  reg [2:0] neg_s;
  reg       pos_q;
  reg       neg_q;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pos_s <= 3'b000;
      neg_s <= 3'b000;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else
    begin
      pos_s <= {pos_s[1:0], rx_pos_in};
      neg_s <= {neg_s[1:0], rx_neg_in};
      if (pos_s[1] == pos_s[2])
        pos_q <= pos_s[2];
      if (neg_s[1] == neg_s[2])
        neg_q <= neg_s[2];
    end
  end

  // bit clock divider: rise and fall enables of the recovered clock
  reg [7:0] div_r;
  wire      half_end = (div_r == HALF_DIV[7:0] - 8'h01);
  wire      rise_en = half_end && !rx_recovered_clock && !pdn;
  wire      fall_en = half_end && rx_recovered_clock && !pdn;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r <= 8'h00;
      rx_recovered_clock <= 1'b0;
    end
    else if (pdn)
    begin
      div_r <= 8'h00; // [RQ7]
      rx_recovered_clock <= 1'b0;
    end
    else
    begin
      div_r <= half_end ? 8'h00 : div_r + 8'h01;
      if (half_end)
        rx_recovered_clock <= !rx_recovered_clock;
    end
  end

  // sampler at the bit centre; mark and substitution decode
  reg       last_pol_r;
  reg [1:0] smp_w;
  reg       smp_v;
  wire      mark = pos_q | neg_q;
  wire      viol = mark && (pos_q == last_pol_r) && (pos_q != neg_q);
  always @*
  begin
    smp_v = fall_en;
    case (rx_decode_choice)
      `TRC_DEC_SUBST: smp_w = {mark & !viol, 1'b0}; // [RQ10]
      `TRC_DEC_AMI:   smp_w = {mark, 1'b0}; // [RQ11]
      `TRC_DEC_DUAL:  smp_w = {pos_q, neg_q}; // [RQ12]
      default:        smp_w = {pos_q, neg_q};
    endcase
  end

  // two entry buffer between sampler and output stage
  reg  [1:0] buf_d [0:1];
  reg  [1:0] buf_cnt;
  reg        buf_rp;
  reg        buf_wp;
  wire       buf_in_ready = (buf_cnt != 2'd2);
  wire       buf_out_valid = (buf_cnt != 2'd0);
  wire       edge_en = rcfg0_r[`TRC_RC0_EDGE] ? fall_en : rise_en; // [RQ9]
  // pop on whichever recovered clock edge the edge bit names
  wire       buf_out_ready = edge_en && !rx_hold;
  wire       push = smp_v && buf_in_ready;
  wire       pop = buf_out_ready && buf_out_valid;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      buf_cnt <= 2'd0;
      buf_rp <= 1'b0;
      buf_wp <= 1'b0;
      buf_d[0] <= 2'b00;
      buf_d[1] <= 2'b00;
      last_pol_r <= 1'b0;
    end
    else if (pdn)
    begin
      buf_cnt <= 2'd0; // [RQ7]
      buf_rp <= 1'b0;
      buf_wp <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_d[buf_wp] <= smp_w;
        buf_wp <= !buf_wp;
        if (mark && pos_q != neg_q)
          last_pol_r <= pos_q;
      end
      if (pop)
        buf_rp <= !buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // output stage: buffered nrz words on the chosen edge, raw rz in
  // slicer mode, all data held at the inactive level while powered off
  wire [1:0] head = buf_d[buf_rp];
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_single_rail_out <= 1'b0;
      rx_positive_rail_out <= 1'b0;
      rx_negative_rail_out <= 1'b0;
      rx_power_down <= 1'b0;
    end
    else
    begin
      rx_power_down <= pdn; // [RQ7]
      if (pdn)
      begin
        rx_single_rail_out <= flip;
        rx_positive_rail_out <= flip;
        rx_negative_rail_out <= flip;
      end
      else if (rx_decode_choice == `TRC_DEC_SLICE)
      begin
        rx_single_rail_out <= flip;
        rx_positive_rail_out <= pos_q ^ flip; // [RQ13] [RQ8]
        rx_negative_rail_out <= neg_q ^ flip; // [RQ13] [RQ8]
      end
      else if (pop)
      begin
        rx_single_rail_out <= rx_decode_choice[1] ? flip
                                                  : head[1] ^ flip; // [RQ8]
        rx_positive_rail_out <= rx_decode_choice[1] ? head[1] ^ flip
                                                    : flip; // [RQ12]
        rx_negative_rail_out <= rx_decode_choice[1] ? head[0] ^ flip
                                                    : flip;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // signal loss: declare above 4 + 2c db of loss, clear at or below
  // 2c db, with c taken as zero while the equalizer bit is off; reserved codes act as the highest legal code
  wire [4:0] thr_eff = (thr_r > `TRC_THR_MAX) ? `TRC_THR_MAX : thr_r;
  wire [5:0] thr_eq = eq_r ? {thr_eff, 1'b0} : 6'h00; // [RQ14] [RQ15]
  wire [5:0] decl_db = thr_eq + `TRC_DECL_OFS_DB;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_signal_lost <= 1'b0;
      equalizer_engage <= 1'b0;
      no_signal_threshold <= `TRC_RST_THR;
    end
    else
    begin
      equalizer_engage <= eq_r; // [RQ14]
      no_signal_threshold <= thr_r;
      if (pdn)
        rx_signal_lost <= 1'b0;
      else if (rx_atten_db > decl_db)
        rx_signal_lost <= 1'b1; // [RQ15]
      else if (rx_atten_db <= thr_eq)
        rx_signal_lost <= 1'b0; // [RQ15]
    end
  end

endmodule

//--- verification/trc_bank_checker.sv
/*
  concurrent checks on the host register port and receive controls.
  assumes it is bound into trc_bank and sees only its ports.
*/
module trc_bank_checker
#(
  parameter [7:0] CHAN_BASE = 8'h00
)
(
  input logic       ref_clk,
  input logic       rstn,
  input logic [7:0] host_addr,
  input logic       host_wr,
  input logic       host_rd,
  input logic [7:0] host_wdata,
  input logic [7:0] host_rdata,
  input logic [5:0] pulse_gain_factor,
  input logic       rx_recovered_clock,
  input logic       rx_power_down,
  input logic       equalizer_engage,
  input logic [4:0] no_signal_threshold,
  input logic [5:0] rx_atten_db,
  input logic       rx_signal_lost
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // effective loss limit: code clamped to 10, zero with equalizer off
  logic [4:0] thr_c;
  logic [6:0] lim;
  assign thr_c = (no_signal_threshold > 5'h0a) ? 5'h0a : no_signal_threshold;
  assign lim   = equalizer_engage ? {1'b0, thr_c, 1'b0} : 7'h00;
  ////////////////////////////////////////////////////////////////////////
  a_pdn_write: assert property
    (host_wr && host_addr == CHAN_BASE + 8'h09
     |-> ##2 rx_power_down == $past(host_wdata[4], 2))
    else $error("power down bit not applied");
  a_pdn_read: assert property
    (host_rd && !host_wr && host_addr == CHAN_BASE + 8'h09
     |=> host_rdata[7:4] == {3'b000, rx_power_down})
    else $error("receive config read wrong");
  a_pdn_clock: assert property
    (rx_power_down [*2] |-> !rx_recovered_clock)
    else $error("clock runs in power down");
  a_eq_write: assert property
    (host_wr && host_addr == CHAN_BASE + 8'h0a
     |-> ##2 equalizer_engage == $past(host_wdata[6], 2))
    else $error("equalizer bit not applied");
  a_thr_write: assert property
    (host_wr && host_addr == CHAN_BASE + 8'h0a
     |-> ##2 no_signal_threshold == $past(host_wdata[4:0], 2))
    else $error("threshold not applied");
  a_gain_write: assert property
    (host_wr && host_addr == CHAN_BASE + 8'h06
     |=> pulse_gain_factor == $past(host_wdata[5:0]))
    else $error("gain not applied");
  a_unmapped_read: assert property
    (host_rd && host_addr == CHAN_BASE + 8'h10 |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_loss_set: assert property
    ((!rx_power_down && rx_atten_db > lim + 7'd4) [*3] |-> rx_signal_lost)
    else $error("loss not declared");
  a_loss_clear: assert property
    ((rx_atten_db <= lim) [*3] |-> !rx_signal_lost)
    else $error("loss not cleared");
endmodule

//--- verification/trc_bank_test.sv
/*
  self checking bench: host register calls and receive stimulus.
  assumes trc_bank with channel base 0 and the default bit period.
*/
`include "trc_defs.vh"
module trc_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, rstn, host_wr, host_rd, rx_pos_in, rx_neg_in, rx_hold;
  logic [7:0] host_addr, host_wdata, host_rdata, rd_v;
  logic [5:0] tx_tpl_addr, pulse_gain_factor, rx_atten_db, idx;
  logic [6:0] tx_tpl_sample, amp;
  logic [4:0] no_signal_threshold;
  logic       rx_recovered_clock, rx_single_rail_out, rx_positive_rail_out;
  logic       rx_negative_rail_out, rx_power_down, equalizer_engage;
  logic       rx_signal_lost;
  int         err_total, n_checks, cyc;
  // loss table: rcfg1 value, attenuation, expected flag
  logic [14:0] los_t [0:7] = '{{8'h00, 6'd5, 1'b1}, {8'h00, 6'd0, 1'b0},
    {8'h43, 6'd10, 1'b0}, {8'h43, 6'd11, 1'b1}, {8'h43, 6'd7, 1'b1},
    {8'h43, 6'd6, 1'b0}, {8'h5f, 6'd24, 1'b0}, {8'h5f, 6'd25, 1'b1}};
  trc_bank #(.CHAN_BASE(8'h00), .HALF_DIV(5)) dut_u (.ref_clk, .rstn,
    .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .tx_tpl_addr,
    .tx_tpl_sample, .pulse_gain_factor, .rx_pos_in, .rx_neg_in, .rx_atten_db,
    .rx_hold, .rx_recovered_clock, .rx_single_rail_out, .rx_positive_rail_out,
    .rx_negative_rail_out, .rx_power_down, .equalizer_engage,
    .no_signal_threshold, .rx_signal_lost);
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      $display("mismatch at %0t: run too long", $time);
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one write strobe, released a cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
  endtask
  // one read strobe, data taken after the sampling edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
    @(negedge ref_clk);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge ref_clk);
    host_rd = 1'b0;
    rd_v    = host_rdata;
    chk(rd_v, exp, what);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rstn, host_wr, host_rd, rx_pos_in, rx_neg_in, rx_hold} = 6'h00;
    {host_addr, host_wdata, tx_tpl_addr, rx_atten_db} = 28'h000_0000;
    err_total = 0;
    n_checks  = 0;
    cyc       = 0;
    tick(10);
    rstn = 1'b1;
    chk({2'b00, pulse_gain_factor}, 8'h21, "gain pin");
    chk({3'b000, no_signal_threshold}, 8'h15, "thr pin");
    rchk(8'h06, 8'h21, "gain reset");
    rchk(8'h0a, 8'h15, "rcfg1 reset");
    rchk(8'h07, 8'h00, "access reset");
    rchk(8'h09, 8'h00, "rcfg0 reset");
    for (int i = 0; i < 4; i++)
    begin
      idx = 6'(i * 21);
      wr(8'h08, {1'b0, 7'h7f - 7'(idx)});
      wr(8'h07, {2'b10, idx});
    end
    for (int i = 0; i < 4; i++)
    begin
      idx = 6'(i * 21);
      amp = 7'h7f - 7'(idx);
      wr(8'h08, 8'h00);
      wr(8'h07, {2'b11, idx});
      tick(1);
      rchk(8'h08, {1'b0, amp}, "template read");
      tx_tpl_addr = idx;
      tick(2);
      chk({1'b0, tx_tpl_sample}, {1'b0, amp}, "template port");
    end
    wr(8'h07, 8'hc1);
    tick(1);
    rchk(8'h08, 8'h00, "unwritten tap");
    wr(8'h09, 8'hff);
    rchk(8'h09, 8'h1f, "rcfg0 fields");
    wr(8'h0a, 8'hff);
    rchk(8'h0a, 8'h5f, "rcfg1 fields");
    wr(8'h06, 8'hff);
    rchk(8'h06, 8'h3f, "gain fields");
    wr(8'h10, 8'h5a);
    rchk(8'h10, 8'h00, "unmapped");
    // every decode choice, both polarities, both edges
    for (int i = 0; i < 8; i++)
    begin
      rx_pos_in = 1'b0;
      wr(8'h09, {4'h0, i[2], i[0] ^ i[2], 2'(i)});
      tick(80);
      if (i[1])
        chk({6'h0, rx_positive_rail_out, rx_negative_rail_out},
            {6'h0, i[2], i[2]}, "dual space");
      else
        chk({7'h0, rx_single_rail_out}, {7'h0, i[2]}, "space");
      rx_pos_in = 1'b1;
      tick(80);
      if (i[1])
        chk({6'h0, rx_positive_rail_out, rx_negative_rail_out},
            {6'h0, ~i[2], i[2]}, "dual mark");
      else if (i[0])
        chk({7'h0, rx_single_rail_out}, {7'h0, ~i[2]}, "ami mark");
      else
        chk({7'h0, rx_single_rail_out}, {7'h0, i[2]}, "sub mark");
    end
    // output stall holds the rails, release drains the buffer
    rx_pos_in = 1'b0;
    wr(8'h09, 8'h02);
    tick(80);
    rx_hold   = 1'b1;
    rx_pos_in = 1'b1;
    tick(80);
    chk({7'h0, rx_positive_rail_out}, 8'h00, "held rail");
    rx_hold = 1'b0;
    tick(80);
    chk({7'h0, rx_positive_rail_out}, 8'h01, "released rail");
    // a mark on the negative rail alone reaches the negative output
    rx_pos_in = 1'b0;
    rx_neg_in = 1'b1;
    tick(80);
    chk({7'h0, rx_negative_rail_out}, 8'h01, "negative rail");
    rx_neg_in = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0a, los_t[i][14:7]);
      rx_atten_db = los_t[i][6:1];
      tick(6);
      chk({7'h0, equalizer_engage}, {7'h0, los_t[i][13]}, "eq pin");
      chk({7'h0, rx_signal_lost}, {7'h0, los_t[i][0]}, "loss");
    end
    // power down with inverted polarity
    wr(8'h09, 8'h18);
    tick(4);
    for (int i = 0; i < 30; i++)
    begin
      tick(1);
      chk({7'h0, rx_recovered_clock}, 8'h00, "pd clock");
    end
    chk({7'h0, rx_power_down}, 8'h01, "pd pin");
    chk({7'h0, rx_single_rail_out}, 8'h01, "pd level");
    summarize();
  end
endmodule
bind trc_bank trc_bank_checker #(.CHAN_BASE(CHAN_BASE)) chk_u (.ref_clk,
  .rstn, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
  .pulse_gain_factor, .rx_recovered_clock, .rx_power_down, .equalizer_engage,
  .no_signal_threshold, .rx_atten_db, .rx_signal_lost);
